// file: core/imc_pkg.sv
// constants, register map and mode types of the power-mode and reset controller
package imc_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] IMC_ADDR_CTRL_ONE = 8'h02;
  localparam logic [7:0] IMC_ADDR_CTRL_TWO = 8'h03;
  localparam logic [7:0] IMC_ADDR_SENSOR_EN = 8'h08;
  localparam logic [7:0] IMC_ADDR_RESET_RESULT = 8'h4D;
  localparam logic [7:0] IMC_ADDR_SOFT_RESET = 8'h60;

  // ==========================================================
  // values and reset values
  localparam logic [7:0] IMC_SOFT_RESET_KEY = 8'hB0;
  localparam logic [7:0] IMC_RESULT_OK = 8'h80;
  localparam logic [7:0] IMC_RESULT_NONE = 8'h00;
  localparam logic [7:0] IMC_CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] IMC_CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] IMC_SENSOR_EN_RST = 8'h00;

  // ==========================================================
  // field positions
  localparam int IMC_SHUTDOWN_BIT = 0;
  localparam int IMC_ACCEL_EN_BIT = 0;
  localparam int IMC_GYRO_EN_BIT = 1;
  localparam int IMC_GYRO_SNOOZE_BIT = 4;
  localparam int IMC_RATE_MSB = 3;
  localparam logic [1:0] IMC_RATE_LP_TOP = 2'h3;

  // ==========================================================
  // timing
  localparam int IMC_CLK_HZ = 250_000_000;
  localparam int IMC_LP_CLK_HZ = 250_000;
  localparam int IMC_LP_DIV = IMC_CLK_HZ / IMC_LP_CLK_HZ;
  localparam int IMC_BOOT_MS = 15;
  localparam int IMC_BOOT_CYC = (IMC_CLK_HZ / 1000) * IMC_BOOT_MS;
  localparam int IMC_ACCEL_WAKE_MS = 3;
  localparam int IMC_ACCEL_WAKE_CYC = (IMC_CLK_HZ / 1000) * IMC_ACCEL_WAKE_MS;
  localparam int IMC_GYRO_WAKE_MS = 150;
  localparam int IMC_GYRO_WAKE_CYC = (IMC_CLK_HZ / 1000) * IMC_GYRO_WAKE_MS;
  localparam int IMC_ODR_CYC = 250_000;

  // ==========================================================
  // operating modes
  typedef enum logic [3:0] {
    IMC_M_DEFAULT,
    IMC_M_LOWPOWER,
    IMC_M_POWERDOWN,
    IMC_M_ACC_NORMAL,
    IMC_M_ACC_LP,
    IMC_M_GYRO_SNOOZE,
    IMC_M_GYRO,
    IMC_M_IMU,
    IMC_M_ACC_SNOOZE
  } imc_mode_e;

endpackage

// file: core/imc_power_ctrl.sv
// operating-mode decoder and reset sequencer of the inertial sensor
// How it works
// RULE1: after any reset both sensors are off, rate field zero, clock running.
// RULE2: both sensors off with rate 11xx selects the 250 kHz clock.
// RULE3: shutdown stops functional blocks, keeps registers and holds output data.
// RULE4: accel only mode, low-power form when rate is 11xx.
// RULE5: gyro snooze keeps drive running, no data; resumes fast on clear.
// RULE6: both enabled with snooze give only accelerometer data.
// RULE7: both enabled, no snooze, normal rate give combined data.
// RULE8: power-up and soft reset always land in the default mode.
// RULE9: default mode reached within 15 ms of reset or power-down exit.
// RULE10: first data after enable raises the data-ready output and status bit.
// RULE11: host treats filtered data as settled after three rate periods.
// RULE12: sensor switch-off completes within one to two rate periods.
// RULE13: gyro wake to first data takes 150 ms.
// RULE14: accel wake to first data takes 3 ms.
// RULE15: writing 0xB0 to address 0x60 starts a soft reset.
// RULE16: a reset returns registers to defaults and disables processing.
// RULE17: the reset process ends within 15 ms.
// RULE18: a good reset leaves 0x80 in register 0x4D until later overwritten.
// RULE19: host reads the reset result before enabling sensors.
// RULE20: shutdown bit overrides the sensor enable bits.
`timescale 1ns/1ps
module imc_power_ctrl
  import imc_pkg::*;
#(
  parameter int BOOT_CYCLES = IMC_BOOT_CYC,
  parameter int ACCEL_WAKE_CYCLES = IMC_ACCEL_WAKE_CYC,
  parameter int GYRO_WAKE_CYCLES = IMC_GYRO_WAKE_CYC,
  parameter int ODR_CYCLES = IMC_ODR_CYC,
  parameter int LP_DIV = IMC_LP_DIV
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // register port from the host interface
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // power and clock control
  output logic resetBusy,
  output logic [3:0] modeCode,
  output logic lowPowerClkSel,
  output logic lowPowerTick,
  output logic functionOn,
  output logic dataHold,
  // sensor control
  output logic accelPower,
  output logic accelData,
  output logic gyroDrive,
  output logic gyroData,
  // data ready
  output logic newSampleFlag,
  output logic dataReadyStatus
);

  localparam int BW = $clog2(BOOT_CYCLES + 1);
  localparam int OW = $clog2(ODR_CYCLES + 1);
  localparam int LW = $clog2(LP_DIV + 1);
  generate
    if (BOOT_CYCLES < 1 || ODR_CYCLES < 2 || LP_DIV < 2)
    begin : gBad
      $error("imc_power_ctrl: count parameters out of range");
    end
  endgenerate
  logic [7:0] controlRegOne_r, controlRegTwo_r, sensorEnableReg_r, resetResult_r;
  logic busy_r, fullReset_r;
  logic [BW-1:0] bootCnt_r;
  logic [OW-1:0] odrCnt_r;
  logic [LW-1:0] lpCnt_r;
  logic odrTick, softReset, shutdownFall;
  logic sensorShutdown, accelEnableBit, gyroEnableBit, gyroSnoozeBit, rateIsLp;
  logic accelReq, gyroReq, accelRun, gyroRun, accelPowered, gyroPowered, accelFirst, gyroFirst;
  imc_mode_e mode_nxt;
  assign sensorShutdown = controlRegOne_r[IMC_SHUTDOWN_BIT];
  assign accelEnableBit = sensorEnableReg_r[IMC_ACCEL_EN_BIT];
  assign gyroEnableBit = sensorEnableReg_r[IMC_GYRO_EN_BIT];
  assign gyroSnoozeBit = sensorEnableReg_r[IMC_GYRO_SNOOZE_BIT];
  assign rateIsLp = (controlRegTwo_r[IMC_RATE_MSB -: 2] == IMC_RATE_LP_TOP);
  assign softReset = regWrEn && !busy_r && regAddr == IMC_ADDR_SOFT_RESET
    && regWrData == IMC_SOFT_RESET_KEY; // RULE15
  assign shutdownFall = regWrEn && !busy_r && regAddr == IMC_ADDR_CTRL_ONE
    && sensorShutdown && !regWrData[IMC_SHUTDOWN_BIT];

  // ==========================================================
  // reset and boot sequencer
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_r <= 1'b1; // RULE8
      fullReset_r <= 1'b1;
      bootCnt_r <= '0;
    end
    else if (softReset || shutdownFall)
    begin
      busy_r <= 1'b1; // RULE8 RULE9
      fullReset_r <= softReset;
      bootCnt_r <= '0;
    end
    else if (busy_r)
    begin
      if (bootCnt_r == BW'(BOOT_CYCLES - 1))
        busy_r <= 1'b0; // RULE9 RULE17
      else
        bootCnt_r <= bootCnt_r + 1'b1;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      controlRegOne_r <= IMC_CTRL_ONE_RST;
      controlRegTwo_r <= IMC_CTRL_TWO_RST;
      sensorEnableReg_r <= IMC_SENSOR_EN_RST;
    end
    else if (busy_r && fullReset_r)
    begin
      controlRegOne_r <= IMC_CTRL_ONE_RST; // RULE1 RULE16
      controlRegTwo_r <= IMC_CTRL_TWO_RST; // RULE1 RULE16
      sensorEnableReg_r <= IMC_SENSOR_EN_RST; // RULE1 RULE16
    end
    else if (regWrEn && !busy_r)
    begin
      // configuration survives shutdown; only writes change it
      if (regAddr == IMC_ADDR_CTRL_ONE)
        controlRegOne_r <= regWrData; // RULE3
      if (regAddr == IMC_ADDR_CTRL_TWO)
        controlRegTwo_r <= regWrData;
      if (regAddr == IMC_ADDR_SENSOR_EN)
        sensorEnableReg_r <= regWrData;
    end
  end

  // ==========================================================
  // reset result register
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      resetResult_r <= IMC_RESULT_NONE;
    else if (busy_r && fullReset_r)
    begin
      if (bootCnt_r == BW'(BOOT_CYCLES - 1))
        resetResult_r <= IMC_RESULT_OK; // RULE18
      else
        resetResult_r <= IMC_RESULT_NONE;
    end
    else if (regWrEn && !busy_r && regAddr == IMC_ADDR_SENSOR_EN
      && (regWrData[IMC_ACCEL_EN_BIT] || regWrData[IMC_GYRO_EN_BIT]))
      resetResult_r <= IMC_RESULT_NONE; // RULE18
  end

  // ==========================================================
  // register read
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      regRdData <= 8'h00;
      regRdValid <= 1'b0;
    end
    else
    begin
      regRdValid <= regRdEn;
      if (regRdEn)
      begin
        unique case (regAddr)
          IMC_ADDR_CTRL_ONE: regRdData <= controlRegOne_r;
          IMC_ADDR_CTRL_TWO: regRdData <= controlRegTwo_r;
          IMC_ADDR_SENSOR_EN: regRdData <= sensorEnableReg_r;
          IMC_ADDR_RESET_RESULT: regRdData <= resetResult_r;
          default: regRdData <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // rate and low-power clock dividers
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      odrCnt_r <= '0;
    else if (busy_r || odrCnt_r == OW'(ODR_CYCLES - 1))
      odrCnt_r <= '0;
    else
      odrCnt_r <= odrCnt_r + 1'b1;
  end
  // keeps ticking in shutdown so that stopping sensors still finish
  assign odrTick = !busy_r && odrCnt_r == OW'(ODR_CYCLES - 1); // RULE12
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      lpCnt_r <= '0;
      lowPowerTick <= 1'b0;
    end
    else
    begin
      lowPowerTick <= lowPowerClkSel && lpCnt_r == LW'(LP_DIV - 1);
      if (!lowPowerClkSel || lpCnt_r == LW'(LP_DIV - 1))
        lpCnt_r <= '0;
      else
        lpCnt_r <= lpCnt_r + 1'b1;
    end
  end

  // ==========================================================
  // sensor sequencers
  assign accelReq = !busy_r && !sensorShutdown && accelEnableBit; // RULE20
  assign gyroReq = !busy_r && !sensorShutdown && gyroEnableBit; // RULE20

  imc_sensor_seq #(.WAKE_CYCLES(ACCEL_WAKE_CYCLES)) uAccel (
    .clock(clock),
    .rstn(rstn),
    .clear(busy_r),
    .enable(accelReq),
    .odrTick(odrTick),
    .running(accelRun),
    .powered(accelPowered),
    .firstData(accelFirst)
  );
  imc_sensor_seq #(.WAKE_CYCLES(GYRO_WAKE_CYCLES)) uGyro (
    .clock(clock),
    .rstn(rstn),
    .clear(busy_r),
    .enable(gyroReq),
    .odrTick(odrTick),
    .running(gyroRun),
    .powered(gyroPowered),
    .firstData(gyroFirst)
  );
  // ==========================================================
  // mode decode
  always_comb
  begin
    mode_nxt = IMC_M_DEFAULT;
    if (busy_r)
      mode_nxt = IMC_M_DEFAULT; // RULE8
    else if (sensorShutdown)
      mode_nxt = IMC_M_POWERDOWN; // RULE20 RULE3
    else if (accelEnableBit && gyroEnableBit)
      mode_nxt = gyroSnoozeBit ? IMC_M_ACC_SNOOZE : IMC_M_IMU; // RULE6 RULE7
    else if (gyroEnableBit)
      mode_nxt = gyroSnoozeBit ? IMC_M_GYRO_SNOOZE : IMC_M_GYRO; // RULE5
    else if (accelEnableBit)
      mode_nxt = rateIsLp ? IMC_M_ACC_LP : IMC_M_ACC_NORMAL; // RULE4
    else if (rateIsLp)
      mode_nxt = IMC_M_LOWPOWER; // RULE2
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      modeCode <= 4'h0;
      lowPowerClkSel <= 1'b0;
      functionOn <= 1'b1;
      dataHold <= 1'b0;
      resetBusy <= 1'b1;
      accelPower <= 1'b0;
      accelData <= 1'b0;
      gyroDrive <= 1'b0;
      gyroData <= 1'b0;
    end
    else
    begin
      modeCode <= 4'(mode_nxt);
      resetBusy <= busy_r;
      lowPowerClkSel <= (mode_nxt == IMC_M_LOWPOWER); // RULE2
      functionOn <= (mode_nxt != IMC_M_POWERDOWN); // RULE1 RULE3
      dataHold <= (mode_nxt == IMC_M_POWERDOWN); // RULE3
      accelPower <= accelPowered;
      accelData <= accelRun; // RULE4 RULE6
      gyroDrive <= gyroPowered; // RULE5
      gyroData <= gyroRun && !gyroSnoozeBit; // RULE5 RULE6 RULE7
    end
  end

  // ==========================================================
  // data ready pulse and status
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      newSampleFlag <= 1'b0;
      dataReadyStatus <= 1'b0;
    end
    else
    begin
      newSampleFlag <= accelFirst || gyroFirst || (odrTick && (accelRun || (gyroRun && !gyroSnoozeBit))); // RULE10
      if (busy_r)
        dataReadyStatus <= 1'b0;
      else if (accelFirst || gyroFirst)
        dataReadyStatus <= 1'b1; // RULE10
    end
  end

  // ==========================================================
  // checks
  AST_SOFT_RESET: assert property (@(posedge clock) disable iff (!rstn) // RULE15
    softReset |=> ##1 resetBusy && modeCode == 4'(IMC_M_DEFAULT))
    else $error("soft reset did not start the reset process");
  AST_DEFAULTS: assert property (@(posedge clock) disable iff (!rstn) // RULE1
    busy_r && fullReset_r && $past(busy_r) |-> sensorEnableReg_r == 8'h00 && controlRegTwo_r == 8'h00)
    else $error("registers not at defaults during reset");
  AST_BOOT_BOUND: assert property (@(posedge clock) disable iff (!rstn) // RULE17
    busy_r |-> bootCnt_r <= BW'(BOOT_CYCLES - 1)) else $error("boot counter passed its limit");
  AST_BOOT_END: assert property (@(posedge clock) disable iff (!rstn) // RULE9
    busy_r && bootCnt_r == BW'(BOOT_CYCLES - 1) && !softReset && !shutdownFall |=> !busy_r)
    else $error("reset did not end at the boot limit");
  AST_RESULT: assert property (@(posedge clock) disable iff (!rstn) // RULE18
    $fell(busy_r) && $past(fullReset_r) |-> resetResult_r == IMC_RESULT_OK)
    else $error("reset result not 0x80 after reset");
  AST_PRIORITY: assert property (@(posedge clock) disable iff (!rstn) // RULE20
    !busy_r && sensorShutdown |-> !accelReq && !gyroReq && mode_nxt == IMC_M_POWERDOWN)
    else $error("shutdown did not override enables");
  AST_POWERDOWN: assert property (@(posedge clock) disable iff (!rstn) // RULE3
    mode_nxt == IMC_M_POWERDOWN |=> !functionOn && dataHold) else $error("power-down did not stop functions");
  AST_LOWPOWER: assert property (@(posedge clock) disable iff (!rstn) // RULE2
    !busy_r && !sensorShutdown && !accelEnableBit && !gyroEnableBit && rateIsLp |=> lowPowerClkSel)
    else $error("low-power clock not selected");
  AST_SNOOZE: assert property (@(posedge clock) disable iff (!rstn) // RULE5
    gyroSnoozeBit && !busy_r |=> !gyroData) else $error("gyro data produced while snoozed");
  AST_FIRST_DATA: assert property (@(posedge clock) disable iff (!rstn) // RULE10
    accelFirst || gyroFirst |=> newSampleFlag ##1 dataReadyStatus || busy_r) else $error("first data not flagged");

endmodule

// file: core/imc_sensor_seq.sv
// per-sensor wake and shut-off sequencer
`timescale 1ns/1ps
module imc_sensor_seq
  import imc_pkg::*;
#(
  parameter int WAKE_CYCLES = 750_000
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // control
  input wire logic clear,
  input wire logic enable,
  input wire logic odrTick,
  // status
  output logic running,
  output logic powered,
  output logic firstData
);

  localparam int CW = $clog2(WAKE_CYCLES + 1);

  generate
    if (WAKE_CYCLES < 1)
    begin : gBad
      $error("imc_sensor_seq: WAKE_CYCLES must be at least 1");
    end
  endgenerate

  typedef enum logic [1:0] {S_OFF, S_WAKE, S_RUN, S_STOP} imc_seq_e;

  imc_seq_e state_r;
  logic [CW-1:0] wakeCnt_r;
  logic stopTick_r;

  // ==========================================================
  // sequence
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= S_OFF;
      wakeCnt_r <= '0;
      stopTick_r <= 1'b0;
      firstData <= 1'b0;
    end
    else if (clear)
    begin
      state_r <= S_OFF;
      wakeCnt_r <= '0;
      stopTick_r <= 1'b0;
      firstData <= 1'b0;
    end
    else
    begin
      firstData <= 1'b0;
      unique case (state_r)
        S_OFF:
        begin
          wakeCnt_r <= '0;
          if (enable)
            state_r <= S_WAKE;
        end
        S_WAKE:
        begin
          if (!enable)
            state_r <= S_OFF;
          else if (wakeCnt_r == CW'(WAKE_CYCLES - 1))
          begin
            state_r <= S_RUN; // RULE13 RULE14
            firstData <= 1'b1; // RULE10
          end
          else
            wakeCnt_r <= wakeCnt_r + 1'b1;
        end
        S_RUN:
        begin
          stopTick_r <= 1'b0;
          if (!enable)
            state_r <= S_STOP;
        end
        S_STOP:
        begin
          // off at the second rate tick: between one and two periods
          if (enable)
            state_r <= S_RUN;
          else if (odrTick && stopTick_r)
            state_r <= S_OFF; // RULE12
          else if (odrTick)
            stopTick_r <= 1'b1; // RULE12
        end
      endcase
    end
  end

  assign running = (state_r == S_RUN);
  assign powered = (state_r != S_OFF);

endmodule

// file: sim/imc_host_model.sv
// host-side model that drives the register port of the power controller
`timescale 1ns/1ps
module imc_host_model
  import imc_pkg::*;
#(
  parameter int ODR_CYCLES = 8
)
(
  // clock
  input wire logic clock,
  // register port
  output logic regWrEn,
  output logic regRdEn,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  // status
  input wire logic resetBusy
);
  initial
  begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end

  // ==========================================================
  // bus cycles
  // writes during boot are dropped silently, so hold off until idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (resetBusy !== 1'b0 && n < 300)
    begin
      @(negedge clock);
      n++;
    end
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge clock);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
    @(negedge clock);
  endtask

  // a missing valid pulse turns the result unknown so it never matches
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge clock);
    d = (regRdValid === 1'b1) ? regRdData : 8'hXX;
    regRdEn = 1'b0;
    regAddr = ~a;
    @(negedge clock);
  endtask

  // ==========================================================
  // host habits
  task automatic soft_reset();
    wr(IMC_ADDR_SOFT_RESET, IMC_SOFT_RESET_KEY);
  endtask

  task automatic settle();
    repeat (3 * ODR_CYCLES) @(negedge clock);
  endtask
endmodule

// file: sim/testbench.sv
// self-checking testbench of the power-mode and reset controller
`timescale 1ns/1ps
module testbench
  import imc_pkg::*;
;
  localparam int BOOT = 20;
  localparam int AWAKE = 10;
  localparam int GWAKE = 30;
  localparam int ODR = 8;
  localparam int LPDIV = 4;
  localparam int S_BUSY = 0;
  localparam int S_TICK = 1;
  localparam int S_NEW = 2;
  localparam int S_APWR = 3;

  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic regWrEn, regRdEn, regRdValid, resetBusy, lowPowerClkSel, lowPowerTick;
  logic functionOn, dataHold, accelPower, accelData, gyroDrive, gyroData;
  logic newSampleFlag, dataReadyStatus;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [3:0] modeCode;
  int failCount = 0;
  int compares = 0;

  always #2 clock = ~clock;

  imc_power_ctrl #(.BOOT_CYCLES(BOOT), .ACCEL_WAKE_CYCLES(AWAKE), .GYRO_WAKE_CYCLES(GWAKE),
    .ODR_CYCLES(ODR), .LP_DIV(LPDIV)) imc_power_ctrl_i (.clock(clock), .rstn(rstn),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid), .resetBusy(resetBusy), .modeCode(modeCode),
    .lowPowerClkSel(lowPowerClkSel), .lowPowerTick(lowPowerTick), .functionOn(functionOn),
    .dataHold(dataHold), .accelPower(accelPower), .accelData(accelData), .gyroDrive(gyroDrive),
    .gyroData(gyroData), .newSampleFlag(newSampleFlag), .dataReadyStatus(dataReadyStatus));

  imc_host_model #(.ODR_CYCLES(ODR)) imc_host_model_i (.clock(clock), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .resetBusy(resetBusy));

  // ==========================================================
  // helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failCount++;
      $display("CHECK FAILED at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    imc_host_model_i.wr(a, d);
  endtask

  task automatic reg_is(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    imc_host_model_i.rd(a, d);
    check(d, exp);
  endtask

  function automatic logic [7:0] inr(input int v, input int lo, input int hi);
    return (v >= lo && v <= hi) ? 8'h01 : 8'h00;
  endfunction

  function automatic logic pick(input int sel);
    case (sel)
      S_BUSY: return resetBusy;
      S_TICK: return lowPowerTick;
      S_NEW: return newSampleFlag;
      default: return accelPower;
    endcase
  endfunction

  // bounded so a dead output shows up as a count out of range
  task automatic wait_sig(input int sel, input logic v, output int n);
    n = 0;
    while (pick(sel) !== v && n < 300)
    begin
      cyc(1);
      n++;
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic test_reset();
    int n;
    cyc(1);
    check(8'(resetBusy), 8'h01);
    check(8'(modeCode), 8'(IMC_M_DEFAULT));
    wait_sig(S_BUSY, 1'b0, n);
    check(inr(n, BOOT - 3, BOOT + 3), 8'h01);
    reg_is(IMC_ADDR_RESET_RESULT, IMC_RESULT_OK);
    check(8'(modeCode), 8'(IMC_M_DEFAULT));
    check(8'({lowPowerClkSel, accelPower, gyroDrive, functionOn}), 8'h01);
    reg_is(IMC_ADDR_CTRL_TWO, IMC_CTRL_TWO_RST);
    $display("test reset done");
  endtask

  task automatic test_low_power();
    int n;
    wr(IMC_ADDR_CTRL_TWO, 8'h0C);
    check(8'(modeCode), 8'(IMC_M_LOWPOWER));
    check(8'(lowPowerClkSel), 8'h01);
    wait_sig(S_TICK, 1'b1, n);
    cyc(1);
    wait_sig(S_TICK, 1'b1, n);
    check(inr(n + 1, LPDIV, LPDIV), 8'h01);
    wr(IMC_ADDR_CTRL_TWO, 8'h08);
    check(8'(modeCode), 8'(IMC_M_DEFAULT));
    check(8'(lowPowerClkSel), 8'h00);
    $display("test low power done");
  endtask

  task automatic test_accel();
    int n;
    wr(IMC_ADDR_SENSOR_EN, 8'h01);
    wait_sig(S_NEW, 1'b1, n);
    check(inr(n, AWAKE - 3, AWAKE + 4), 8'h01);
    check(8'(accelData), 8'h01);
    check(8'(modeCode), 8'(IMC_M_ACC_NORMAL));
    cyc(1);
    check(8'(dataReadyStatus), 8'h01);
    imc_host_model_i.settle();
    reg_is(IMC_ADDR_RESET_RESULT, IMC_RESULT_NONE);
    wr(IMC_ADDR_CTRL_TWO, 8'h0D);
    check(8'(modeCode), 8'(IMC_M_ACC_LP));
    check(8'(lowPowerClkSel), 8'h00);
    wr(IMC_ADDR_SENSOR_EN, 8'h00);
    cyc(1);
    check(8'(accelData), 8'h00);
    wait_sig(S_APWR, 1'b0, n);
    check(inr(n, ODR - 5, 2 * ODR + 1), 8'h01);
    wr(IMC_ADDR_CTRL_TWO, 8'h00);
    $display("test accel done");
  endtask

  task automatic test_gyro();
    wr(IMC_ADDR_SENSOR_EN, 8'h12);
    check(8'(modeCode), 8'(IMC_M_GYRO_SNOOZE));
    cyc(GWAKE + 6);
    check(8'({gyroDrive, gyroData}), 8'h02);
    wr(IMC_ADDR_SENSOR_EN, 8'h02);
    check(8'({gyroDrive, gyroData}), 8'h03);
    check(8'(modeCode), 8'(IMC_M_GYRO));
    wr(IMC_ADDR_SENSOR_EN, 8'h13);
    cyc(AWAKE + 6);
    check(8'(modeCode), 8'(IMC_M_ACC_SNOOZE));
    check(8'({accelData, gyroData}), 8'h02);
    wr(IMC_ADDR_SENSOR_EN, 8'h03);
    check(8'(modeCode), 8'(IMC_M_IMU));
    check(8'({accelData, gyroData}), 8'h03);
    $display("test gyro done");
  endtask

  task automatic test_shutdown();
    int n;
    wr(IMC_ADDR_CTRL_ONE, 8'h01);
    cyc(1);
    check(8'(modeCode), 8'(IMC_M_POWERDOWN));
    check(8'({functionOn, dataHold}), 8'h01);
    reg_is(IMC_ADDR_SENSOR_EN, 8'h03);
    wait_sig(S_APWR, 1'b0, n);
    check(inr(n, ODR - 5, 2 * ODR + 1), 8'h01);
    wr(IMC_ADDR_SENSOR_EN, 8'h00);
    wr(IMC_ADDR_CTRL_ONE, 8'h00);
    cyc(1);
    check(8'(resetBusy), 8'h01);
    wait_sig(S_BUSY, 1'b0, n);
    check(inr(n, BOOT - 5, BOOT + 3), 8'h01);
    check(8'(modeCode), 8'(IMC_M_DEFAULT));
    check(8'(functionOn), 8'h01);
    $display("test shutdown done");
  endtask

  task automatic test_soft_reset();
    int n;
    wr(IMC_ADDR_SENSOR_EN, 8'h01);
    wr(IMC_ADDR_CTRL_TWO, 8'h05);
    wr(IMC_ADDR_SOFT_RESET, 8'h55);
    check(8'(resetBusy), 8'h00);
    reg_is(IMC_ADDR_SENSOR_EN, 8'h01);
    imc_host_model_i.soft_reset();
    cyc(1);
    check(8'(resetBusy), 8'h01);
    check(8'({accelPower, modeCode}), 8'(IMC_M_DEFAULT));
    reg_is(IMC_ADDR_RESET_RESULT, IMC_RESULT_NONE);
    wait_sig(S_BUSY, 1'b0, n);
    check(inr(n, BOOT - 8, BOOT + 3), 8'h01);
    reg_is(IMC_ADDR_RESET_RESULT, IMC_RESULT_OK);
    reg_is(IMC_ADDR_SENSOR_EN, IMC_SENSOR_EN_RST);
    reg_is(IMC_ADDR_CTRL_TWO, IMC_CTRL_TWO_RST);
    reg_is(IMC_ADDR_SOFT_RESET, 8'h00);
    reg_is(8'h7F, 8'h00);
    $display("test soft reset done");
  endtask

  // ==========================================================
  // run control
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    cyc(12);
    rstn = 1'b1;
    test_reset();
    test_low_power();
    test_accel();
    test_gyro();
    test_shutdown();
    test_soft_reset();
    summarize();
  end

  // the whole run needs well under a thousand cycles
  initial
  begin
    #(4000 * 4);
    failCount++;
    summarize();
  end
endmodule
